// ### spx_port.sv
// Functional notes
// - six-pin port shared with keypad interrupts
// - reset leaves output latches unchanged
// - direction 1 enables output buffer
// - reset clears all direction bits
// - output bits read back latch value
// - input bits read back pin level
// - latch writable regardless of direction
// - pull-up only when enabled and input
// - output direction disables pull-up immediately
// - pull-up off while enable bit zero
// - wakeup latch readable in data register
// - no seventh pin or bit-six controls
// - pin two is input only
// - irq enabled reads bit two zero
// - irq disabled reads pin two, branch sees one
// - clock-out on pin four for internal/RC
// - clock-out select ignored for crystal/external
// - source select decode 00/01/10/11
// - driven clock equals oscillator clock
// - enabled keypad bits make pins interrupt inputs
module spx_port (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // Avalon-MM slave
    input  wire logic [3:0]          address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    input  wire logic [3:0]          byteenable,
    output logic      [31:0]         readdata,
    output logic                     waitrequest,
    // Port pins
    input  wire logic [5:0]          pinIn,
    output spx_pkg::spx_pins_t       pins,
    // Neighbouring blocks
    input  wire logic                wakeupRequest,
    input  wire logic [5:0]          keypadInterruptEnables,
    input  wire logic                oscillatorClock,
    output logic      [5:0]          keypadPinLevels,
    output logic                     branchIrqLevel
);

    // ==========================================
    // Pin synchronisers
    logic [5:0] pinMeta;
    logic [5:0] pinSync;
    logic       oscMeta;
    logic       oscSync;
    logic       wakeMeta;
    logic       wakeSync;

    always_ff @(posedge clk) begin
        pinMeta  <= pinIn;
        pinSync  <= pinMeta;
        oscMeta  <= oscillatorClock;
        oscSync  <= oscMeta;
        wakeMeta <= wakeupRequest;
        wakeSync <= wakeMeta;
    end

    // ==========================================
    // Registers
    logic [5:0] portLatchBits;
    logic [5:0] portDirectionBits;
    logic [5:0] portPullupBits;
    logic       clockOutPinSelect;
    logic [1:0] oscillatorSourceSelect;
    logic       irqFunctionEnable;
    spx_pkg::spx_bus_t busState;

    logic busAccess;
    logic wrEn;
    assign busAccess = (read | write) && (busState == spx_pkg::BUS_IDLE);
    // Write lands only on the edge where the master sees waitrequest low
    assign wrEn      = write && (busState == spx_pkg::BUS_DONE) && byteenable[0];

    // Latch has no reset so contents survive it
    always_ff @(posedge clk) begin
        if (wrEn && address == spx_pkg::ADDR_LATCH) begin
            portLatchBits <= writedata[spx_pkg::PORT_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            portDirectionBits <= spx_pkg::DIR_RESET;
        end else if (wrEn && address == spx_pkg::ADDR_DIR) begin
            portDirectionBits <= writedata[spx_pkg::PORT_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            portPullupBits    <= spx_pkg::PULLUP_RESET;
            clockOutPinSelect <= spx_pkg::CLKSEL_RESET;
        end else if (wrEn && address == spx_pkg::ADDR_PULLUP) begin
            portPullupBits    <= writedata[spx_pkg::PORT_WIDTH-1:0];
            clockOutPinSelect <= writedata[spx_pkg::CLKSEL_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            oscillatorSourceSelect <= spx_pkg::SRC_RESET;
            irqFunctionEnable      <= spx_pkg::IRQEN_RESET;
        end else if (wrEn && address == spx_pkg::ADDR_CONFIG) begin
            oscillatorSourceSelect <= writedata[spx_pkg::CFG_SRC_LSB +: 2];
            irqFunctionEnable      <= writedata[spx_pkg::CFG_IRQEN_BIT];
        end
    end

    // ==========================================
    // Clock-out decision
    logic clockOutActive;
    always_comb begin
        case (spx_pkg::spx_src_t'(oscillatorSourceSelect))
            spx_pkg::SRC_INTERNAL: clockOutActive = clockOutPinSelect;
            spx_pkg::SRC_RC:       clockOutActive = clockOutPinSelect;
            default:               clockOutActive = 1'b0;
        endcase
    end

    // ==========================================
    // Pin drive, per bit
    spx_pkg::spx_pins_t next_pins;
    genvar gi;
    generate
        for (gi = 0; gi < spx_pkg::PORT_WIDTH; gi++) begin : g_pin
            if (gi == spx_pkg::IRQ_PIN) begin : g_in_only
                always_comb begin
                    next_pins.outVal[gi] = 1'b0;
                    next_pins.outEn[gi]  = 1'b0;
                    next_pins.pullEn[gi] = portPullupBits[gi] & ~portDirectionBits[gi];
                end
            end else if (gi == spx_pkg::CLK_PIN) begin : g_clk_pin
                always_comb begin
                    next_pins.outVal[gi] = clockOutActive ? oscSync : portLatchBits[gi];
                    next_pins.outEn[gi]  = clockOutActive | portDirectionBits[gi];
                    next_pins.pullEn[gi] = portPullupBits[gi] & ~portDirectionBits[gi]
                                           & ~clockOutActive;
                end
            end else begin : g_gpio
                always_comb begin
                    next_pins.outVal[gi] = portLatchBits[gi];
                    next_pins.outEn[gi]  = portDirectionBits[gi];
                    next_pins.pullEn[gi] = portPullupBits[gi] & ~portDirectionBits[gi];
                end
            end
        end
    endgenerate

    // Registered pins add one cycle; the clock copy is resampled at 20 MHz
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pins <= '0;
        end else begin
            pins <= next_pins;
        end
    end

    // ==========================================
    // Data register readback
    logic [7:0] portView;
    always_comb begin
        portView = 8'h00;
        for (int i = 0; i < spx_pkg::PORT_WIDTH; i++) begin
            portView[i] = portDirectionBits[i] ? portLatchBits[i] : pinSync[i];
        end
        if (irqFunctionEnable) begin
            portView[spx_pkg::IRQ_PIN] = 1'b0;
        end else begin
            portView[spx_pkg::IRQ_PIN] = pinSync[spx_pkg::IRQ_PIN];
        end
        portView[spx_pkg::WAKE_BIT] = wakeSync;
    end

    // ==========================================
    // Keypad and branch-test views
    always_ff @(posedge clk) begin
        if (!nrst) begin
            keypadPinLevels <= 6'h3F;
            branchIrqLevel  <= 1'b1;
        end else begin
            for (int i = 0; i < spx_pkg::PORT_WIDTH; i++) begin
                // Disabled bits idle high so keypad sees no edge
                keypadPinLevels[i] <= keypadInterruptEnables[i] ? pinSync[i] : 1'b1;
            end
            branchIrqLevel <= irqFunctionEnable ? pinSync[spx_pkg::IRQ_PIN] : 1'b1;
        end
    end

    // ==========================================
    // Avalon-MM slave: one wait cycle then answer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busState    <= spx_pkg::BUS_IDLE;
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            case (busState)
                spx_pkg::BUS_IDLE: begin
                    if (busAccess) begin
                        busState    <= spx_pkg::BUS_DONE;
                        waitrequest <= 1'b0;
                        if (address == spx_pkg::ADDR_LATCH) begin
                            readdata <= {24'h000000, portView};
                        end else if (address == spx_pkg::ADDR_DIR) begin
                            readdata <= {26'h0000000, portDirectionBits};
                        end else if (address == spx_pkg::ADDR_PULLUP) begin
                            readdata <= {24'h000000, clockOutPinSelect, 1'b0, portPullupBits};
                        end else if (address == spx_pkg::ADDR_CONFIG) begin
                            readdata <= {29'h00000000, irqFunctionEnable, oscillatorSourceSelect};
                        end else begin
                            readdata <= 32'h0000_0000;
                        end
                    end
                end
                spx_pkg::BUS_DONE: begin
                    busState    <= spx_pkg::BUS_IDLE;
                    waitrequest <= 1'b1;
                end
                default: begin
                    busState    <= spx_pkg::BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

endmodule : spx_port

// ### spx_pkg.sv
package spx_pkg;

    // ==========================================
    // Register map (byte addresses, one word each)
    localparam logic [3:0] ADDR_LATCH    = 4'h0;
    localparam logic [3:0] ADDR_DIR      = 4'h4;
    localparam logic [3:0] ADDR_PULLUP   = 4'h8;
    localparam logic [3:0] ADDR_CONFIG   = 4'hC;

    // ==========================================
    // Field positions
    localparam int PORT_WIDTH      = 6;
    localparam int WAKE_BIT        = 6;
    localparam int CLKSEL_BIT      = 7;
    localparam int IRQ_PIN         = 2;
    localparam int CLK_PIN         = 4;
    localparam int CFG_SRC_LSB     = 0;
    localparam int CFG_IRQEN_BIT   = 2;

    // ==========================================
    // Reset values
    localparam logic [5:0] DIR_RESET    = 6'h00;
    localparam logic [5:0] PULLUP_RESET = 6'h00;
    localparam logic       CLKSEL_RESET = 1'h0;
    localparam logic [1:0] SRC_RESET    = 2'h0;
    localparam logic       IRQEN_RESET  = 1'h0;

    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'b00,
        SRC_EXTCLK   = 2'b01,
        SRC_RC       = 2'b10,
        SRC_CRYSTAL  = 2'b11
    } spx_src_t;

    typedef struct packed {
        logic [5:0] outVal;
        logic [5:0] outEn;
        logic [5:0] pullEn;
    } spx_pins_t;

    // Bus state machine
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } spx_bus_t;

endpackage : spx_pkg

// ### spx_assertions.sv
module spx_assertions (
    // Clock and reset
    input wire logic               clk,
    input wire logic               nrst,
    // Watched ports
    input wire logic               read,
    input wire logic               write,
    input wire logic               waitrequest,
    input wire spx_pkg::spx_pins_t pins,
    input wire logic [5:0]         keypadInterruptEnables,
    input wire logic [5:0]         keypadPinLevels,
    input wire logic               oscillatorClock
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // Sequences
    sequence busQuiet;
        !write [*3];
    endsequence
    // No write for four edges: latch or mode cannot have moved pin four
    sequence writeQuiet;
        !write [*4];
    endsequence
    // Pipeline from oscillator to pin is three edges deep
    sequence clockToggle;
        pins.outEn[4] && $changed(pins.outVal[4]);
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ====
    // Checks
    AST_WAIT_ANSWER: assert property ($rose(read || write) |=> !waitrequest)
        else $error("no answer one cycle after request");
    AST_WAIT_PULSE: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    AST_RESET_IDLE: assert property (disable iff (1'b0) !nrst |=> waitrequest && pins.outEn == 6'h00)
        else $error("pins or bus not idle in reset");
    AST_PIN2_INPUT: assert property (pins.outEn[2] == 1'b0)
        else $error("pin two driven");
    AST_PULL_INPUT_ONLY: assert property ((pins.pullEn & pins.outEn) == 6'h00)
        else $error("pull-up on driven pin");
    AST_KEYPAD_IDLE: assert property (1'b1 |=> (keypadPinLevels | $past(keypadInterruptEnables)) == 6'h3F)
        else $error("disabled keypad bit not high");
    AST_DRIVE_HOLD: assert property (busQuiet |=> $stable(pins.outEn))
        else $error("drive changed without write");
    AST_CLOCK_COPY: assert property (writeQuiet ##0 clockToggle |-> pins.outVal[4] == $past(oscillatorClock, 3))
        else $error("clock out differs from oscillator");
endmodule : spx_assertions

// ### spx_board.sv
module spx_board (
    // Clock
    input  wire logic               clk,
    // Device side
    input  wire spx_pkg::spx_pins_t pins,
    output logic      [5:0]         pinIn,
    // Bench drive
    input  wire logic [5:0]         drvEn,
    input  wire logic [5:0]         drvVal
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // Floating lines wander so an open input never reads steady
    logic [5:0] drift = 6'h2A;
    always @(posedge clk) drift <= ~drift;
    assign pinIn = (pins.outEn & pins.outVal)
        | (~pins.outEn & drvEn & drvVal)
        | (~pins.outEn & ~drvEn & (pins.pullEn | drift));
endmodule : spx_board

// ### testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] LAT = spx_pkg::ADDR_LATCH, DIR = spx_pkg::ADDR_DIR;
    localparam logic [3:0] PUL = spx_pkg::ADDR_PULLUP, CFG = spx_pkg::ADDR_CONFIG;
    logic clk = 0, nrst = 0, read = 0, write = 0, wakeupRequest = 0, oscillatorClock = 0;
    logic               waitrequest, branchIrqLevel;
    logic [3:0]         address = 4'h0;
    logic [31:0]        writedata = 32'h0, readdata;
    logic [5:0]         pinIn, keypadPinLevels, kpEn = 6'h00, bEn = 6'h00, bVal = 6'h00;
    logic [7:0]         q;
    spx_pkg::spx_pins_t pins;
    int                 nErrors = 0, testsRun = 0, cyc = 0;
    spx_port i_dut (.clk, .nrst, .address, .read, .write, .writedata, .byteenable(4'hF), .readdata,
        .waitrequest, .pinIn, .pins, .wakeupRequest, .keypadInterruptEnables(kpEn), .oscillatorClock,
        .keypadPinLevels, .branchIrqLevel);
    spx_board i_board (.clk, .pins, .pinIn, .drvEn(bEn), .drvVal(bVal));
    always #25 clk = ~clk;
    // Slow oscillator: clock-out is resampled by clk
    always #400 oscillatorClock = ~oscillatorClock;
    // ====
    // Bus access and compare
    task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
        address   <= a;
        writedata <= {24'h0, d};
        write     <= wr;
        read      <= ~wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
        // Registered pins follow a write one edge later
        @(posedge clk);
    endtask : acc
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        testsRun++;
        if (s !== e) begin
            nErrors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task report_and_stop;
        if (nErrors == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            nErrors++;
            report_and_stop();
        end
    end
    // ====
    // Scenarios
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        acc(0, DIR, 0);
        chk("dir", q, 8'h00);
        chk("outEn", 8'(pins.outEn), 8'h00);
        acc(1, LAT, 8'h2D);
        acc(1, DIR, 8'h3F);
        bEn <= 6'h04;
        repeat (3) @(posedge clk);
        chk("outEn", 8'(pins.outEn), 8'h3B);
        chk("outVal", 8'(pins.outVal & pins.outEn), 8'h29);
        acc(0, LAT, 0);
        chk("data out", q, 8'h29);
        acc(0, DIR, 0);
        chk("dir", q, 8'h3F);
        acc(1, DIR, 0);
        bEn <= 6'h3F;
        bVal <= 6'h15;
        wakeupRequest <= 1'b1;
        repeat (3) @(posedge clk);
        acc(0, LAT, 0);
        chk("data in", q, 8'h55);
        bEn <= 6'h00;
        wakeupRequest <= 1'b0;
        acc(1, PUL, 8'h3F);
        chk("pullEn", 8'(pins.pullEn), 8'h3F);
        // Pin level still has to cross the synchroniser
        @(posedge clk);
        acc(0, LAT, 0);
        chk("pulled", q, 8'h3F);
        acc(1, DIR, 8'h0F);
        chk("pullEn", 8'(pins.pullEn), 8'h30);
        acc(1, DIR, 0);
        acc(1, PUL, 0);
        chk("pullEn", 8'(pins.pullEn), 8'h00);
        acc(1, PUL, 8'hFF);
        acc(0, PUL, 0);
        chk("pullup", q, 8'hBF);
        bEn <= 6'h04;
        for (int i = 0; i < 8; i++) begin
            bVal <= {3'h0, i[0], 2'h0};
            acc(1, CFG, {5'h0, i[2], i[1:0]});
            repeat (3) @(posedge clk);
            acc(0, LAT, 0);
            chk("bit2", {7'h0, q[2]}, {7'h0, i[0] & ~i[2]});
            chk("branch", {7'h0, branchIrqLevel}, {7'h0, ~i[2] | i[0]});
            chk("clkout", {7'h0, pins.outEn[4]}, {7'h0, ~i[0]});
        end
        acc(1, CFG, 8'h00);
        for (int k = 0; k < 2; k++) begin
            @(oscillatorClock);
            repeat (4) @(posedge clk);
            chk("clock copy", {7'h0, pins.outVal[4]}, {7'h0, oscillatorClock});
        end
        kpEn <= 6'h05;
        bEn <= 6'h3F;
        bVal <= 6'h00;
        acc(1, PUL, 0);
        repeat (3) @(posedge clk);
        chk("keypad", 8'(keypadPinLevels), 8'h3A);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        acc(1, DIR, 8'h3F);
        chk("latch kept", 8'(pins.outVal & pins.outEn), 8'h29);
        report_and_stop();
    end
endmodule : testbench
bind spx_port spx_assertions i_chk (.clk, .nrst, .read, .write, .waitrequest, .pins,
    .keypadInterruptEnables, .keypadPinLevels, .oscillatorClock);
